// *** design/fsw_pkg.sv ***
// Shared constants for the status-register write path of a small SPI flash
// and for the controller that drives it.
// Assumes both ends run on one 20 MHz pclk with an asynchronous low reset.
package fsw_pkg;

    // Command opcodes carried on the serial link.
    localparam logic [7:0] OP_WRITE_STATUS   = 8'h01;
    localparam logic [7:0] OP_WRITE_STATUS2  = 8'h31;
    localparam logic [7:0] OP_READ_STATUS    = 8'h05;
    localparam logic [7:0] OP_WRITE_ENABLE   = 8'h06;
    localparam logic [7:0] OP_WRITE_DISABLE  = 8'h04;
    localparam logic [7:0] OP_RESET          = 8'hf0;

    // Field positions of status byte one, status byte two and the write data.
    localparam int unsigned SB1_LOCK_BIT     = 7;
    localparam int unsigned SB1_WPP_BIT      = 4;
    localparam int unsigned SB1_PROT_BIT     = 2;
    localparam int unsigned SB1_LATCH_BIT    = 1;
    localparam int unsigned BUSY_BIT         = 0;
    localparam int unsigned SB2_RESET_EN_BIT = 4;

    // Power-up values.
    localparam logic RST_LOCK                = 1'b0;
    localparam logic RST_PROT                = 1'b0;
    localparam logic RST_LATCH               = 1'b0;
    localparam logic RST_RESET_EN            = 1'b0;

    // Controller register map on APB (byte addresses).
    localparam int unsigned APB_AW           = 12;
    localparam logic [11:0] REG_CMD          = 12'h000;
    localparam logic [11:0] REG_STAT         = 12'h004;
    localparam logic [11:0] REG_RX           = 12'h008;
    localparam int unsigned CMD_OP_LSB       = 0;
    localparam int unsigned CMD_DATA_LSB     = 8;
    localparam int unsigned CMD_LEN_LSB      = 16;
    localparam int unsigned CMD_POLL_BIT     = 24;

    // Serial clock timing.
    localparam int unsigned PCLK_NS          = 50;
    localparam int unsigned SCK_HALF_NS      = 400;
    localparam int unsigned SCK_HALF_CYC     = SCK_HALF_NS / PCLK_NS;

    typedef enum logic [2:0] {
        HS_IDLE,
        HS_LOW,
        HS_HIGH,
        HS_TRAIL,
        HS_GAP
    } fsw_host_state_type;

endpackage : fsw_pkg

// *** design/fsw_spi_if.sv ***
// Serial link between the flash status logic and its controller.
// Assumes the bench drives nothing on it; the two ends drive all signals.
`timescale 1ns/100ps
interface fsw_spi_if;
    logic cs_n;
    logic sck;
    logic mosi;
    logic miso;
    logic miso_oe;

    modport dev (
        input  cs_n,
        input  sck,
        input  mosi,
        output miso,
        output miso_oe
    );

    modport host (
        output cs_n,
        output sck,
        output mosi,
        input  miso
    );
endinterface : fsw_spi_if

// *** design/fsw_dev.sv ***
// Device end: status registers, write-status commands and status read-out.
// Assumes cs_n, sck, mosi and wp_n arrive asynchronously; busy comes from
// logic on pclk. Serial mode 0: data in on sck rise, data out on sck fall.
//
// Notes on behaviour
// - Host polls status until busy reads zero.
// - Busy flag is bit zero of both bytes.
// - Reset command ignored while enable bit is zero.
// - Reset command acts when enable bit is one.
// - Enable bit survives reset command; only rewritten.
// - Byte two: enable bit four, busy bit zero.
// - Write status: opcode 01h, one data byte.
// - Data bit seven is lock, bit two protect.
// - Status writes need write enable latch set.
// - Valid frame end updates bits, clears latch.
// - Partial byte aborts, keeps bits, clears latch.
// - Protect change depends on lock and pin.
// - Pin asserted: lock may only be set.
// - Byte two write: opcode 31h, bit four.
// - Valid byte two frame stores bit, clears latch.
// - Partial byte two frame aborts, clears latch.
// - Enable bit changes only by byte two write.
// - Opcode 05h streams both status bytes repeatedly.
// - Incomplete opcode leaves write enable latch set.
//
// Our own choices: the APB interface to the registers and the register offsets.
`timescale 1ns/100ps
module fsw_dev (
    // Clock and reset
    input  wire logic pclk,
    input  wire logic presetn,
    // Serial link
    fsw_spi_if.dev    spi,
    // Pin and core inputs
    input  wire logic wp_n,
    input  wire logic busy,
    // State outputs
    output logic      protect_lock,
    output logic      array_protect,
    output logic      write_enable_latch,
    output logic      reset_command_enable,
    output logic      soft_reset
);

    logic [2:0] cs_sync_q;
    logic [2:0] sck_sync_q;
    logic [1:0] mosi_sync_q;
    logic [1:0] wp_sync_q;
    logic [2:0] bit_cnt_q;
    logic [1:0] byte_cnt_q;
    logic [7:0] shift_q;
    logic [7:0] opcode_q;
    logic [7:0] data_q;
    logic       read_act_q;
    logic [3:0] read_idx_q;
    logic       miso_q;
    logic       miso_oe_q;
    logic       lock_q;
    logic       prot_q;
    logic       wr_en_q;
    logic       reset_en_q;
    logic       soft_reset_q;

    logic       cs_active;
    logic       frame_end;
    logic       sck_rise;
    logic       sck_fall;
    logic [7:0] byte_in;
    logic       byte_done;
    logic       opcode_seen;
    logic       aligned;
    logic       data_full;
    logic       wp_asserted;
    logic       wrsr_valid;
    logic       wrsr2_valid;
    logic       lock_clear_refused;
    logic [7:0] status1;
    logic [7:0] status2;
    logic [15:0] status_word;

    ////////////////////////////////////////////////////////////////////////////
    // Synchronisers. Only the second and third stages feed any logic.

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cs_sync_q   <= 3'h7;
            sck_sync_q  <= 3'h0;
            mosi_sync_q <= 2'h0;
            wp_sync_q   <= 2'h3;
        end else begin
            cs_sync_q   <= {cs_sync_q[1:0], spi.cs_n};
            sck_sync_q  <= {sck_sync_q[1:0], spi.sck};
            mosi_sync_q <= {mosi_sync_q[0], spi.mosi};
            wp_sync_q   <= {wp_sync_q[0], wp_n};
        end
    end

    assign cs_active   = !cs_sync_q[1];
    assign frame_end   = cs_sync_q[1] && !cs_sync_q[2];
    assign sck_rise    = cs_active && sck_sync_q[1] && !sck_sync_q[2];
    assign sck_fall    = cs_active && !sck_sync_q[1] && sck_sync_q[2];
    assign byte_in     = {shift_q[6:0], mosi_sync_q[1]};
    assign byte_done   = sck_rise && (bit_cnt_q == 3'h7);
    assign wp_asserted = !wp_sync_q[1];

    ////////////////////////////////////////////////////////////////////////////
    // Frame decode, evaluated in the cycle in which the synchronised chip select (cs_sync_q[1]) rises.

    assign opcode_seen = byte_cnt_q != 2'h0;
    assign aligned     = bit_cnt_q == 3'h0;
    assign data_full   = aligned && (byte_cnt_q >= 2'h2);
    // Extra whole bytes after the data byte change nothing.
    assign wrsr_valid  = frame_end && (opcode_q == fsw_pkg::OP_WRITE_STATUS)
                         && data_full && wr_en_q;
    assign wrsr2_valid = frame_end && (opcode_q == fsw_pkg::OP_WRITE_STATUS2)
                         && data_full && wr_en_q;
    assign lock_clear_refused = wp_asserted
                         && !data_q[fsw_pkg::SB1_LOCK_BIT];

    ////////////////////////////////////////////////////////////////////////////
    // Bit and byte capture.

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bit_cnt_q  <= 3'h0;
            byte_cnt_q <= 2'h0;
            shift_q    <= 8'h00;
            opcode_q   <= 8'h00;
            data_q     <= 8'h00;
        end else if (cs_sync_q[2]) begin
            bit_cnt_q  <= 3'h0;
            byte_cnt_q <= 2'h0;
        end else if (sck_rise) begin
            shift_q   <= byte_in;
            bit_cnt_q <= bit_cnt_q + 3'h1;
            if (byte_done) begin
                if (byte_cnt_q == 2'h0) begin
                    opcode_q <= byte_in;
                end
                if (byte_cnt_q == 2'h1) begin
                    data_q <= byte_in;
                end
                if (byte_cnt_q != 2'h3) begin
                    byte_cnt_q <= byte_cnt_q + 2'h1;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Write enable latch.

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wr_en_q <= fsw_pkg::RST_LATCH;
        end else if (frame_end && opcode_seen) begin
            unique case (opcode_q)
                fsw_pkg::OP_WRITE_ENABLE: begin
                    if (aligned) begin
                        wr_en_q <= 1'b1;
                    end
                end
                fsw_pkg::OP_WRITE_DISABLE: begin
                    if (aligned) begin
                        wr_en_q <= 1'b0;
                    end
                end
                // Done, aborted or refused alike, the latch falls.
                fsw_pkg::OP_WRITE_STATUS,
                fsw_pkg::OP_WRITE_STATUS2: begin
                    wr_en_q <= 1'b0;
                end
                fsw_pkg::OP_RESET: begin
                    if (aligned && reset_en_q) begin
                        wr_en_q <= fsw_pkg::RST_LATCH;
                    end
                end
                default: begin
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Lock and protect bits. The pin level is the one seen at frame end.

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lock_q <= fsw_pkg::RST_LOCK;
            prot_q <= fsw_pkg::RST_PROT;
        end else if (wrsr_valid && !lock_clear_refused) begin
            lock_q <= data_q[fsw_pkg::SB1_LOCK_BIT];
            // A held lock under an asserted pin freezes protection.
            if (!(lock_q && wp_asserted)) begin
                prot_q <= data_q[fsw_pkg::SB1_PROT_BIT];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Reset command enable and the reset command itself.

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            reset_en_q <= fsw_pkg::RST_RESET_EN;
        end else if (wrsr2_valid) begin
            reset_en_q <= data_q[fsw_pkg::SB2_RESET_EN_BIT];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            soft_reset_q <= 1'b0;
        end else begin
            soft_reset_q <= frame_end && aligned && opcode_seen
                            && (opcode_q == fsw_pkg::OP_RESET)
                            && reset_en_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Status read-out. Each bit is taken live, so every pass shows fresh state.

    always_comb begin
        status1 = 8'h00;
        status1[fsw_pkg::SB1_LOCK_BIT] = lock_q;
        status1[fsw_pkg::SB1_WPP_BIT]  = wp_sync_q[1];
        status1[fsw_pkg::SB1_PROT_BIT] = prot_q;
        status1[fsw_pkg::SB1_LATCH_BIT] = wr_en_q;
        status1[fsw_pkg::BUSY_BIT]     = busy;
        status2 = 8'h00;
        status2[fsw_pkg::SB2_RESET_EN_BIT] = reset_en_q;
        status2[fsw_pkg::BUSY_BIT]     = busy;
    end

    assign status_word = {status1, status2};

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            read_act_q <= 1'b0;
            read_idx_q <= 4'h0;
            miso_q     <= 1'b0;
            miso_oe_q  <= 1'b0;
        end else if (!cs_active) begin
            read_act_q <= 1'b0;
            read_idx_q <= 4'h0;
            miso_oe_q  <= 1'b0;
        end else if (byte_done && byte_cnt_q == 2'h0) begin
            read_act_q <= byte_in == fsw_pkg::OP_READ_STATUS;
        end else if (sck_fall && read_act_q) begin
            miso_q     <= status_word[4'hf - read_idx_q];
            miso_oe_q  <= 1'b1;
            read_idx_q <= read_idx_q + 4'h1;
        end
    end

    assign spi.miso             = miso_q;
    assign spi.miso_oe          = miso_oe_q;
    assign protect_lock         = lock_q;
    assign array_protect        = prot_q;
    assign write_enable_latch   = wr_en_q;
    assign reset_command_enable = reset_en_q;
    assign soft_reset           = soft_reset_q;

endmodule : fsw_dev

// *** design/fsw_host.sv ***
// Controller end: APB registers start serial frames and collect read data.
// Assumes an APB master on pclk; the serial clock is divided down from pclk.
`timescale 1ns/100ps
module fsw_host (
    // Clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic             pready,
    output logic [31:0]      prdata,
    output logic             pslverr,
    // Serial link
    fsw_spi_if.host          spi
);

    fsw_pkg::fsw_host_state_type state_q;
    logic [31:0] cmd_q;
    logic [15:0] tx_q;
    logic [15:0] rx_q;
    logic [7:0]  cnt_q;
    logic [3:0]  div_q;
    logic [1:0]  miso_sync_q;
    logic        cs_n_q;
    logic        sck_q;
    logic        pready_q;
    logic [31:0] prdata_q;
    logic        pslverr_q;

    logic        access;
    logic        commit;
    logic        start;
    logic        tick;
    logic        poll;
    logic        done;

    assign access = psel && penable && !pready_q;
    // Writes land on the completing edge, the one at which pready is seen high.
    assign commit = psel && penable && pready_q;
    // A command written while a frame runs is dropped.
    assign start  = commit && pwrite && (paddr == fsw_pkg::REG_CMD)
                    && (state_q == fsw_pkg::HS_IDLE);
    assign tick   = div_q == 4'(fsw_pkg::SCK_HALF_CYC - 1);
    assign poll   = cmd_q[fsw_pkg::CMD_POLL_BIT];
    // Polling ends at a byte boundary whose last bit, the busy flag, was zero.
    assign done   = poll ? (cnt_q[2:0] == 3'h0 && cnt_q != 8'h08 && cnt_q != 8'h00
                            && !rx_q[fsw_pkg::BUSY_BIT])
                         : (cnt_q == {2'h0, cmd_q[fsw_pkg::CMD_LEN_LSB +: 6]});

    ////////////////////////////////////////////////////////////////////////////
    // APB slave with one wait state, so every output comes from a register.

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q  <= 1'b0;
            prdata_q  <= 32'h0000_0000;
            pslverr_q <= 1'b0;
        end else begin
            pready_q  <= access;
            pslverr_q <= access && paddr != fsw_pkg::REG_CMD
                         && paddr != fsw_pkg::REG_STAT && paddr != fsw_pkg::REG_RX;
            if (access && !pwrite) begin
                unique case (paddr)
                    fsw_pkg::REG_CMD:  prdata_q <= cmd_q;
                    fsw_pkg::REG_STAT: prdata_q <= {31'h0, state_q != fsw_pkg::HS_IDLE};
                    fsw_pkg::REG_RX:   prdata_q <= {16'h0000, rx_q};
                    default:           prdata_q <= 32'h0000_0000;
                endcase
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cmd_q <= 32'h0000_0000;
        end else if (start) begin
            cmd_q <= pwdata;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            miso_sync_q <= 2'h0;
        end else begin
            miso_sync_q <= {miso_sync_q[0], spi.miso};
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Frame engine: opcode, then data byte, then zeros, most significant first.

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_q <= 4'h0;
        end else if (state_q == fsw_pkg::HS_IDLE || tick) begin
            div_q <= 4'h0;
        end else begin
            div_q <= div_q + 4'h1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= fsw_pkg::HS_IDLE;
            cs_n_q  <= 1'b1;
            sck_q   <= 1'b0;
            tx_q    <= 16'h0000;
            rx_q    <= 16'h0000;
            cnt_q   <= 8'h00;
        end else begin
            unique case (state_q)
                fsw_pkg::HS_IDLE: begin
                    if (start) begin
                        state_q <= fsw_pkg::HS_LOW;
                        cs_n_q  <= 1'b0;
                        // The opcode must lead the frame; the data byte follows it.
                        tx_q    <= {pwdata[fsw_pkg::CMD_OP_LSB +: 8],
                                    pwdata[fsw_pkg::CMD_DATA_LSB +: 8]};
                        rx_q    <= 16'h0000;
                        cnt_q   <= 8'h00;
                    end
                end
                fsw_pkg::HS_LOW: begin
                    if (tick) begin
                        if (!poll && done) begin
                            state_q <= fsw_pkg::HS_TRAIL;
                        end else begin
                            state_q <= fsw_pkg::HS_HIGH;
                            sck_q   <= 1'b1;
                            rx_q    <= {rx_q[14:0], miso_sync_q[1]};
                            cnt_q   <= cnt_q + 8'h01;
                        end
                    end
                end
                fsw_pkg::HS_HIGH: begin
                    if (tick) begin
                        sck_q   <= 1'b0;
                        tx_q    <= {tx_q[14:0], 1'b0};
                        state_q <= done ? fsw_pkg::HS_TRAIL : fsw_pkg::HS_LOW;
                    end
                end
                fsw_pkg::HS_TRAIL: begin
                    if (tick) begin
                        cs_n_q  <= 1'b1;
                        state_q <= fsw_pkg::HS_GAP;
                    end
                end
                fsw_pkg::HS_GAP: begin
                    if (tick) begin
                        state_q <= fsw_pkg::HS_IDLE;
                    end
                end
                default: begin
                    state_q <= fsw_pkg::HS_IDLE;
                end
            endcase
        end
    end

    assign spi.cs_n = cs_n_q;
    assign spi.sck  = sck_q;
    assign spi.mosi = tx_q[15];
    assign pready   = pready_q;
    assign prdata   = prdata_q;
    assign pslverr  = pslverr_q;

endmodule : fsw_host

// *** testbench/fsw_asserts.sv ***
// Checker for the serial link and the device status bits.
// Assumes the bench top instantiates it beside the link interface.
`timescale 1ns/100ps
module fsw_asserts (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Link and pin
    input wire logic cs_n,
    input wire logic miso_oe,
    input wire logic wp_n,
    // Device state
    input wire logic protect_lock,
    input wire logic array_protect,
    input wire logic write_enable_latch,
    input wire logic reset_command_enable,
    input wire logic soft_reset
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    ////////////////////////////////////////////////////////////////////////////////
    // Status bits settle a few cycles after cs_n rises, so idle spans are six long.
    sequence s_idle;
        cs_n [*6];
    endsequence
    sequence s_bit_change;
        $changed(protect_lock) || $changed(reset_command_enable);
    endsequence

    a_miso_float: assert property (s_idle |-> !miso_oe)
        else $error("serial output driven while deselected");
    a_enable_kept: assert property (s_idle |-> $stable(reset_command_enable))
        else $error("reset enable changed while idle");
    a_latch_kept: assert property (s_idle |-> $stable(write_enable_latch))
        else $error("write enable latch changed while idle");
    a_bits_kept: assert property (s_idle |-> $stable({protect_lock, array_protect}))
        else $error("lock or protect changed while idle");
    a_lock_pin: assert property ($fell(protect_lock) |-> wp_n)
        else $error("lock cleared under asserted pin");
    a_reset_gate: assert property (soft_reset |-> reset_command_enable)
        else $error("reset acted while disabled");
    a_latch_clear: assert property ($changed(array_protect) |-> ##[0:2] !write_enable_latch)
        else $error("latch not cleared after status write");
    a_need_latch: assert property (s_bit_change |-> $past(write_enable_latch))
        else $error("status bit written without latch");
    a_frame_end: assert property ($changed(protect_lock) |-> cs_n)
        else $error("lock changed inside a frame");
endmodule : fsw_asserts

// *** testbench/flash_status_register_writes_tb.sv ***
// Bench for the controller and the flash status logic joined by the link.
// Assumes the APB map and link timing of the shared package.
`timescale 1ns/100ps
module flash_status_register_writes_tb;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, wp_n, busy, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic        protect_lock, array_protect, write_enable_latch, reset_command_enable;
    logic        soft_reset, m_l, m_p, m_w, m_r;
    int          fail_count, n_tests, sr_cnt;

    fsw_spi_if spi ();
    fsw_host u_fsw_host (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
        .pslverr(pslverr), .spi(spi.host));
    fsw_dev u_fsw_dev (.pclk(pclk), .presetn(presetn), .spi(spi.dev), .wp_n(wp_n),
        .busy(busy), .protect_lock(protect_lock), .array_protect(array_protect),
        .write_enable_latch(write_enable_latch), .reset_command_enable(reset_command_enable),
        .soft_reset(soft_reset));
    fsw_asserts u_fsw_asserts (.pclk(pclk), .presetn(presetn), .cs_n(spi.cs_n),
        .miso_oe(spi.miso_oe), .wp_n(wp_n), .protect_lock(protect_lock),
        .array_protect(array_protect), .write_enable_latch(write_enable_latch),
        .reset_command_enable(reset_command_enable), .soft_reset(soft_reset));

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        pclk = 1'b0;
        forever #25 pclk = ~pclk;
    end
    always @(posedge pclk) if (soft_reset === 1'b1) sr_cnt <= sr_cnt + 1;
    initial begin
        #3000000;
        fail_count++;
        close_out();
    end

    task close_out();
        if (fail_count == 0 && n_tests > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : close_out

    task cmp(input string nm, input logic [15:0] e, input logic [15:0] g);
        n_tests++;
        if (g !== e) begin
            fail_count++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask : cmp

    // Entered just after a rising edge; ends one idle cycle after the answer.
    task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb

    function automatic logic [31:0] cw(input logic [7:0] op, input logic [7:0] dt,
                                       input logic [5:0] len);
        return {10'h000, len, dt, op};
    endfunction : cw

    task wait_idle();
        do apb(1'b0, fsw_pkg::REG_STAT, 32'h0); while (rd[0] !== 1'b0);
        repeat (4) @(posedge pclk);
    endtask : wait_idle

    task go(input logic [31:0] w);
        apb(1'b1, fsw_pkg::REG_CMD, w);
        wait_idle();
    endtask : go

    task we();
        go(cw(fsw_pkg::OP_WRITE_ENABLE, 8'h00, 6'd8));
    endtask : we

    // The read-out frame carries the opcode byte and then both status bytes.
    task verify();
        cmp("state", {12'h000, m_l, m_p, m_w, m_r},
            {12'h000, protect_lock, array_protect, write_enable_latch, reset_command_enable});
        go(cw(fsw_pkg::OP_READ_STATUS, 8'h00, 6'd24));
        apb(1'b0, fsw_pkg::REG_RX, 32'h0);
        cmp("status", {m_l, 2'b00, wp_n, 1'b0, m_p, m_w, busy, 3'b000, m_r, 3'b000, busy},
            rd[15:0]);
    endtask : verify

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        {presetn, psel, penable, pwrite, busy, m_l, m_p, m_w, m_r} = '0;
        {paddr, pwdata} = '0;
        wp_n = 1'b1;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        repeat (3) @(posedge pclk);
        verify();
        apb(1'b0, 12'h00c, 32'h0);
        cmp("unmapped", 16'h0001, {rd[14:0], err});
        go(cw(fsw_pkg::OP_WRITE_STATUS, 8'h84, 6'd16));
        verify();
        we();
        m_w = 1'b1;
        verify();
        go(cw(fsw_pkg::OP_WRITE_STATUS, 8'h84, 6'd24));
        {m_l, m_p, m_w} = 3'b110;
        verify();
        we();
        go(cw(fsw_pkg::OP_WRITE_STATUS, 8'h7b, 6'd16));
        {m_l, m_p} = 2'b00;
        verify();
        we();
        go(cw(fsw_pkg::OP_WRITE_STATUS, 8'h84, 6'd12));
        verify();
        we();
        go(cw(fsw_pkg::OP_WRITE_STATUS, 8'h84, 6'd5));
        m_w = 1'b1;
        verify();
        wp_n <= 1'b0;
        go(cw(fsw_pkg::OP_WRITE_STATUS, 8'h84, 6'd16));
        {m_l, m_p, m_w} = 3'b110;
        verify();
        we();
        go(cw(fsw_pkg::OP_WRITE_STATUS, 8'h00, 6'd16));
        verify();
        wp_n <= 1'b1;
        we();
        go(cw(fsw_pkg::OP_WRITE_STATUS, 8'h00, 6'd16));
        {m_l, m_p} = 2'b00;
        verify();
        go(cw(fsw_pkg::OP_RESET, 8'h00, 6'd8));
        cmp("resets", 16'h0000, 16'(sr_cnt));
        we();
        go(cw(fsw_pkg::OP_WRITE_STATUS2, 8'h10, 6'd16));
        m_r = 1'b1;
        verify();
        we();
        go(cw(fsw_pkg::OP_RESET, 8'h00, 6'd8));
        cmp("resets", 16'h0001, 16'(sr_cnt));
        verify();
        we();
        go(cw(fsw_pkg::OP_WRITE_STATUS2, 8'hef, 6'd24));
        m_r = 1'b0;
        verify();
        we();
        go(cw(fsw_pkg::OP_WRITE_STATUS2, 8'h10, 6'd10));
        verify();
        we();
        go(cw(fsw_pkg::OP_WRITE_STATUS, 8'hff, 6'd16));
        {m_l, m_p} = 2'b11;
        verify();
        we();
        go(cw(fsw_pkg::OP_WRITE_DISABLE, 8'h00, 6'd8));
        verify();
        apb(1'b0, fsw_pkg::REG_CMD, 32'h0);
        cmp("command", 16'h1805, {rd[23:16], rd[7:0]});
        busy <= 1'b1;
        verify();
        apb(1'b1, fsw_pkg::REG_CMD, cw(fsw_pkg::OP_READ_STATUS, 8'h00, 6'd0) | 32'h0100_0000);
        repeat (200) @(posedge pclk);
        apb(1'b0, fsw_pkg::REG_STAT, 32'h0);
        cmp("poll running", 16'h0001, {15'h0000, rd[0]});
        apb(1'b1, fsw_pkg::REG_CMD, cw(fsw_pkg::OP_WRITE_ENABLE, 8'h00, 6'd8));
        apb(1'b0, fsw_pkg::REG_CMD, 32'h0);
        cmp("dropped", 16'h0005, rd[15:0]);
        busy <= 1'b0;
        wait_idle();
        apb(1'b0, fsw_pkg::REG_RX, 32'h0);
        cmp("poll last", 16'h0000, {15'h0000, rd[0]});
        close_out();
    end
endmodule : flash_status_register_writes_tb
